// *** hdl/uef_uart.sv ***
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/1ns
// Notes on behaviour
// - enabled, transmit pin is driven output and receive pin is input.
// - transmit line idles high when no character is being sent.
// - reset leaves module off; off, pins follow port latch and direction.
// - disabling empties both buffers and restarts the baud counter.
// - disable clears data, error, enable, break, full flags; sets idle flags.
// - disable keeps address detect, irq selects, mode and divisor.
// - clearing module_on aborts activity; setting it resumes same configuration.
// - format_select picks 8 bits even, odd, none, or 9 bits none.
// - stop_count_select picks one or two stop bits.
// - power-on format is eight data bits, no parity, one stop.
// - module_on is bit 15 of line_mode_reg.
// - written byte loads shifter at once, shifting on next baud edge.
// - data queued before tx_allow starts shifting immediately when allowed.
// - tx irq follows tx_irq_select, bit 15 of line_state_reg.
// - bit timing from 16-bit divisor on the instruction clock.
// - four word transmit buffer and four word receive buffer.
// - parity, framing and overrun errors each have a flag.
// - address mode in 9-bit format interrupts only on words with ninth bit one.
// - loopback routes transmitter output to receiver internally.
// - select clear: irq each move to shifter; set: only when buffer empties.
// - write to full transmit buffer is ignored.
module uef_uart
   import uef_pkg::*;
(
   input  wire logic        hclk,           // clock
   input  wire logic        hresetn,        // async reset
   input  wire logic        hsel,           // slave select
   input  wire logic [31:0] haddr,          // address
   input  wire logic [1:0]  htrans,         // transfer type
   input  wire logic        hwrite,         // write
   input  wire logic [2:0]  hsize,          // size
   input  wire logic [31:0] hwdata,         // write data
   input  wire logic        hready,         // bus ready
   output logic             hreadyout,      // slave ready
   output logic             hresp,          // response
   output logic [31:0]      hrdata,         // read data
   input  wire logic [1:0]  port_latch,     // port latch, [0] tx pin
   input  wire logic [1:0]  port_direction, // 1 = input, [0] tx pin
   input  wire logic        tx_pin_i,       // tx pin level (unused)
   output logic             tx_pin_o,       // tx pin drive
   output logic             tx_pin_oe,      // tx pin enable
   input  wire logic        rx_pin_i,       // rx pin level
   output logic             rx_pin_o,       // rx pin drive
   output logic             rx_pin_oe,      // rx pin enable
   output logic             tx_irq,         // transmit irq pulse
   output logic             rx_irq          // receive irq pulse
);
   typedef struct packed
   {
      logic        on;
      logic        loop;
      logic [1:0]  fmt;
      logic        stop;
      logic [15:0] div;
      logic        txis;
      logic        brk;
      logic        txa;
      logic        txa_q;
      logic [1:0]  rxis;
      logic        addr;
      logic        overrun_flag;
      uef_tx_t     tst;
      logic [3:0]  tsub;
      logic [3:0]  tcnt;
      logic [8:0]  tsh;
      logic        tpar;
      logic        txd;
      uef_rx_t     rst;
      logic [3:0]  rsub;
      logic [3:0]  rcnt;
      logic [8:0]  rsh;
      logic        rperr;
      logic        rferr;
      logic        rx_m;
      logic        rx_s;
      logic        rx_p;
      logic        dw;
      logic [7:0]  da;
      logic [31:0] hrdata;
      logic        tirq;
      logic        rirq;
   } uef_st_t;
   uef_st_t     s;
   uef_st_t     n;
   logic        tick;
   logic        tf_push;
   logic        tf_pop;
   logic [8:0]  tf_rdata;
   logic        tf_full;
   logic        tf_empty;
   logic [2:0]  tf_count;
   logic        rf_push;
   logic        rf_pop;
   logic [10:0] rf_wdata;
   logic [10:0] rf_rdata;
   logic        rf_full;
   logic        rf_empty;
   logic [2:0]  rf_count;
   logic        sel;
   logic        rxin;
   logic        tbit;
   logic        rbit;
   logic        load;
   logic        nine;
   logic        parity;
   logic        parity_error_flag;
   logic        frame_error_flag;
   logic        rquiet;
   logic        tse;
   logic [15:0] mode_rd;
   logic [15:0] state_rd;

   // ----------------------------------------
   // shared pieces
   // ----------------------------------------
   uef_baud #(.W(16)) u_baud
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .clr     (!s.on),
      .div     (s.div),
      .tick    (tick)
   );

   uef_fifo #(.W(9), .D(FIFO_D)) u_txf
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .clr     (!s.on),
      .push    (tf_push),
      .wdata   (hwdata[8:0]),
      .pop     (tf_pop),
      .rdata   (tf_rdata),
      .full    (tf_full),
      .empty   (tf_empty),
      .count   (tf_count)
   );

   uef_fifo #(.W(11), .D(FIFO_D)) u_rxf
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .clr     (!s.on),
      .push    (rf_push),
      .wdata   (rf_wdata),
      .pop     (rf_pop),
      .rdata   (rf_rdata),
      .full    (rf_full),
      .empty   (rf_empty),
      .count   (rf_count)
   );

   // ----------------------------------------
   // pins and status
   // ----------------------------------------
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = s.hrdata;
   assign tx_irq    = s.tirq;
   assign rx_irq    = s.rirq;
   assign tx_pin_o  = s.on ? s.txd : port_latch[0];
   assign tx_pin_oe = s.on || !port_direction[0];
   assign rx_pin_o  = port_latch[1];
   assign rx_pin_oe = !s.on && !port_direction[1];
   assign rxin      = s.loop ? s.txd : s.rx_s;
   assign sel       = hsel && htrans[1] && hready;
   assign tbit      = tick && s.tsub == SUB_LAST;
   assign rbit      = tick && s.rsub == SUB_LAST;
   assign nine      = s.fmt == FMT_9N;
   assign parity    = s.fmt == FMT_8E || s.fmt == FMT_8O;
   assign parity_error_flag      = rf_rdata[9] && !rf_empty;
   assign frame_error_flag      = rf_rdata[10] && !rf_empty;
   assign rquiet    = s.rst == RX_IDLE;
   assign tse       = s.tst == TX_IDLE;
   assign mode_rd   = {s.on, 8'h00, s.loop, 3'h0, s.fmt, s.stop};
   assign state_rd  = {s.txis, 3'h0, s.brk, s.txa, tf_full, tse, s.rxis, s.addr, rquiet, parity_error_flag, frame_error_flag,
                       s.overrun_flag, !rf_empty};
   assign tf_push   = s.dw && s.da == A_TXW && s.on;
   assign rf_pop    = sel && !hwrite && haddr[7:0] == A_RXR;
   assign load      = tse && s.txa && !tf_empty;
   assign tf_pop    = load;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      n        = s;
      rf_push  = 1'b0;
      rf_wdata = {s.rferr, s.rperr, nine ? s.rsh : {1'b0, s.rsh[8:1]}};
      n.rx_m   = rx_pin_i;
      n.rx_s   = s.rx_m;
      n.rx_p   = rxin;
      n.txa_q  = s.txa;
      n.tirq   = 1'b0;
      n.rirq   = 1'b0;
      n.dw     = sel && hwrite;
      n.da     = haddr[7:0];
      if (sel && !hwrite)
      begin
         unique case (haddr[7:0])
            A_MODE  : n.hrdata = {16'h0000, mode_rd};
            A_STATE : n.hrdata = {16'h0000, state_rd};
            A_RXR   : n.hrdata = {23'h000000, rf_rdata[8:0]};
            A_BAUD  : n.hrdata = {16'h0000, s.div};
            default : n.hrdata = 32'h00000000;
         endcase
      end
      if (s.dw)
      begin
         unique case (s.da)
            A_MODE :
            begin
               n.on   = hwdata[B_ON];
               n.loop = hwdata[B_LOOP];
               n.fmt  = hwdata[B_FMT +: 2];
               n.stop = hwdata[B_STOP];
            end
            A_STATE :
            begin
               n.txis = hwdata[B_TXIS];
               n.brk  = hwdata[B_BRK] && s.on;
               n.txa  = hwdata[B_TXA] && s.on;
               n.rxis = hwdata[B_RXIS +: 2];
               n.addr = hwdata[B_ADDR];
               if (!hwdata[B_OE])
                  n.overrun_flag = 1'b0;
            end
            A_BAUD :
               n.div = hwdata[15:0];
            default :
               n.div = s.div;
         endcase
      end
      // transmitter
      if (tick)
         n.tsub = s.tsub + 1'b1;
      unique case (s.tst)
         TX_IDLE :
         begin
            n.tsub = '0;
            if (load)
            begin
               n.tsh  = tf_rdata;
               n.tpar = ^tf_rdata[7:0] ^ (s.fmt == FMT_8O);
               n.tcnt = '0;
               n.tst  = s.txa_q ? TX_WAIT : TX_START;
               n.tirq = !s.txis || tf_count == 3'h1;
            end
         end
         TX_WAIT :
         begin
            n.tsub = '0;
            if (tick)
               n.tst = TX_START;
         end
         TX_START :
            if (tbit)
               n.tst = TX_DATA;
         TX_DATA :
            if (tbit)
            begin
               n.tsh  = {1'b0, s.tsh[8:1]};
               n.tcnt = s.tcnt + 1'b1;
               if (s.tcnt == (nine ? 4'h8 : 4'h7))
               begin
                  n.tcnt = '0;
                  n.tst  = parity ? TX_PAR : TX_STOP;
               end
            end
         TX_PAR :
            if (tbit)
               n.tst = TX_STOP;
         TX_STOP :
            if (tbit)
            begin
               n.tcnt = s.tcnt + 1'b1;
               if (s.tcnt == {3'h0, s.stop})
                  n.tst = TX_IDLE;
            end
      endcase
      unique case (s.tst)
         TX_START : n.txd = 1'b0;
         TX_DATA  : n.txd = s.tsh[0];
         TX_PAR   : n.txd = s.tpar;
         default  : n.txd = 1'b1;
      endcase
      if (s.brk)
         n.txd = 1'b0;
      // receiver
      if (tick)
         n.rsub = s.rsub + 1'b1;
      unique case (s.rst)
         RX_IDLE :
            if (s.rx_p && !rxin && !s.overrun_flag)
            begin
               n.rst   = RX_START;
               n.rsub  = '0;
               n.rperr = 1'b0;
               n.rferr = 1'b0;
            end
         RX_START :
            if (tick && s.rsub == SUB_MID)
            begin
               n.rsub = '0;
               n.rcnt = '0;
               n.rst  = rxin ? RX_IDLE : RX_DATA;
            end
         RX_DATA :
            if (rbit)
            begin
               n.rsh  = {rxin, s.rsh[8:1]};
               n.rcnt = s.rcnt + 1'b1;
               if (s.rcnt == (nine ? 4'h8 : 4'h7))
               begin
                  n.rcnt = '0;
                  n.rst  = parity ? RX_PAR : RX_STOP;
               end
            end
         RX_PAR :
            if (rbit)
            begin
               n.rperr = rxin != (^s.rsh[8:1] ^ (s.fmt == FMT_8O));
               n.rst   = RX_STOP;
            end
         RX_STOP :
            if (rbit)
            begin
               n.rferr = s.rferr || !rxin;
               n.rcnt  = s.rcnt + 1'b1;
               if (s.rcnt == {3'h0, s.stop})
               begin
                  n.rst       = RX_IDLE;
                  rf_wdata[10] = s.rferr || !rxin;
                  rf_push     = !rf_full;
                  if (rf_full)
                     n.overrun_flag = 1'b1;
                  if (s.addr && nine)
                     n.rirq = s.rsh[8];
                  else
                     n.rirq = !rf_full && (!s.rxis[1] || (s.rxis == RXIS_3 && rf_count == 3'h2)
                              || (s.rxis == RXIS_4 && rf_count == 3'h3));
               end
            end
      endcase
      if (!s.on)
      begin
         n.txa  = 1'b0;
         n.brk  = 1'b0;
         n.overrun_flag = 1'b0;
         n.tst  = TX_IDLE;
         n.rst  = RX_IDLE;
         n.tirq = 1'b0;
         n.rirq = 1'b0;
         n.txd  = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s      <= '0;
         s.fmt  <= RST_FMT;
         s.div  <= RST_DIV;
         s.txd  <= 1'b1;
         s.rx_m <= 1'b1;
         s.rx_s <= 1'b1;
         s.rx_p <= 1'b1;
      end
      else
         s <= n;
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_idle_high;
      @(posedge hclk) disable iff (!hresetn) s.on && tse && !s.brk && $past(tse) && !$past(s.brk) |-> tx_pin_o;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("tx line not high when idle");

   property p_pins_on;
      @(posedge hclk) disable iff (!hresetn) s.on |-> tx_pin_oe && !rx_pin_oe;
   endproperty
   a_pins_on: assert property (p_pins_on) else $error("pin directions wrong when on");

   property p_pins_off;
      @(posedge hclk) disable iff (!hresetn) !s.on |-> tx_pin_oe == !port_direction[0] && tx_pin_o == port_latch[0];
   endproperty
   a_pins_off: assert property (p_pins_off) else $error("port control lost when off");

   property p_disable_flags;
      @(posedge hclk) disable iff (!hresetn) $fell(s.on) |-> ##1 !tf_full && tse && rquiet && !rf_empty == 1'b0
         && !s.txa && !s.overrun_flag && !s.brk;
   endproperty
   a_disable_flags: assert property (p_disable_flags) else $error("disable left flags set");

   property p_disable_keeps;
      @(posedge hclk) disable iff (!hresetn) !s.on && !s.dw |=> $stable(s.div) && $stable(s.fmt) && $stable(s.stop)
         && $stable(s.rxis) && $stable(s.txis) && $stable(s.addr);
   endproperty
   a_disable_keeps: assert property (p_disable_keeps) else $error("disable changed configuration");

   property p_enable_write;
      @(posedge hclk) disable iff (!hresetn) s.dw && s.da == A_MODE ##0 hwdata[B_ON] |=> s.on;
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("module_on not set by write");

   property p_start_low;
      @(posedge hclk) disable iff (!hresetn) s.tst == TX_START && !s.brk && s.on |=> s.txd == 1'b0;
   endproperty
   a_start_low: assert property (p_start_low) else $error("start bit not low");

   property p_tx_irq;
      @(posedge hclk) disable iff (!hresetn) tx_irq |-> $past(load) && (!$past(s.txis) || $past(tf_count) == 3'h1);
   endproperty
   a_tx_irq: assert property (p_tx_irq) else $error("tx irq without proper move");

   property p_txa_gate;
      @(posedge hclk) disable iff (!hresetn) !s.on |=> !s.txa;
   endproperty
   a_txa_gate: assert property (p_txa_gate) else $error("tx_allow set while off");

   c_frame: cover property (@(posedge hclk) s.tst == TX_STOP ##1 s.tst == TX_IDLE);
   c_rx_word: cover property (@(posedge hclk) rf_push);
   c_overrun: cover property (@(posedge hclk) $rose(s.overrun_flag));
endmodule : uef_uart

// *** hdl/uef_pkg.sv ***
package uef_pkg;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] A_MODE  = 8'h00;
   localparam logic [7:0] A_STATE = 8'h04;
   localparam logic [7:0] A_TXW   = 8'h08;
   localparam logic [7:0] A_RXR   = 8'h0c;
   localparam logic [7:0] A_BAUD  = 8'h10;
   // ----------------------------------------
   // line_mode_reg fields
   // ----------------------------------------
   localparam int B_ON   = 15;
   localparam int B_LOOP = 6;
   localparam int B_FMT  = 1;
   localparam int B_STOP = 0;
   // ----------------------------------------
   // line_state_reg fields
   // ----------------------------------------
   localparam int B_TXIS = 15;
   localparam int B_BRK  = 11;
   localparam int B_TXA  = 10;
   localparam int B_TXF  = 9;
   localparam int B_TSE  = 8;
   localparam int B_RXIS = 6;
   localparam int B_ADDR = 5;
   localparam int B_RQ   = 4;
   localparam int B_PE   = 3;
   localparam int B_FE   = 2;
   localparam int B_OE   = 1;
   localparam int B_RXW  = 0;
   // ----------------------------------------
   // reset values, formats, timing
   // ----------------------------------------
   localparam logic [15:0] RST_DIV  = 16'h0000;
   localparam logic [1:0]  RST_FMT  = 2'h0;
   localparam logic [1:0]  FMT_8E   = 2'h1;
   localparam logic [1:0]  FMT_8O   = 2'h2;
   localparam logic [1:0]  FMT_9N   = 2'h3;
   localparam logic [1:0]  RXIS_3   = 2'h2;
   localparam logic [1:0]  RXIS_4   = 2'h3;
   localparam int          FIFO_D   = 4;
   localparam logic [3:0]  SUB_LAST = 4'hf;
   localparam logic [3:0]  SUB_MID  = 4'h7;
   typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_START, TX_DATA, TX_PAR, TX_STOP} uef_tx_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uef_rx_t;
endpackage : uef_pkg

// *** hdl/uef_baud.sv ***
`timescale 1ns/1ns
module uef_baud #(parameter int W = 16)
(
   input  wire logic         hclk,    // clock
   input  wire logic         hresetn, // async reset
   input  wire logic         clr,     // restart from zero
   input  wire logic [W-1:0] div,     // divisor
   output logic              tick     // one per div+1 clocks
);
   typedef struct packed {logic [W-1:0] cnt;} uef_bst_t;
   uef_bst_t s;
   uef_bst_t n;

   assign tick = !clr && s.cnt == div;

   always_comb
   begin
      n = s;
      if (clr || tick)
         n.cnt = '0;
      else
         n.cnt = s.cnt + 1'b1;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s <= '0;
      else
         s <= n;
   end

   property p_clr_restart;
      @(posedge hclk) disable iff (!hresetn) clr ##1 !clr |-> s.cnt == 0 && tick == (div == 0);
   endproperty
   a_clr_restart: assert property (p_clr_restart) else $error("baud not restarted");
endmodule : uef_baud

// *** hdl/uef_fifo.sv ***
`timescale 1ns/1ns
module uef_fifo #(parameter int W = 9, parameter int D = 4, localparam int A = $clog2(D))
(
   input  wire logic         hclk,    // clock
   input  wire logic         hresetn, // async reset
   input  wire logic         clr,     // empty at once
   input  wire logic         push,    // write strobe
   input  wire logic [W-1:0] wdata,   // write word
   input  wire logic         pop,     // read strobe
   output logic [W-1:0]      rdata,   // head word
   output logic              full,    // no room
   output logic              empty,   // no data
   output logic [A:0]        count    // words held
);
   typedef struct packed
   {
      logic [D-1:0][W-1:0] mem;
      logic [A-1:0]        rp;
      logic [A-1:0]        wp;
      logic [A:0]          cnt;
   } uef_fst_t;
   uef_fst_t s;
   uef_fst_t n;
   logic     do_push;
   logic     do_pop;

   assign full    = s.cnt == (A+1)'(D);
   assign empty   = s.cnt == '0;
   assign count   = s.cnt;
   assign rdata   = s.mem[s.rp];
   assign do_push = push && !full;
   assign do_pop  = pop && !empty;

   always_comb
   begin
      n = s;
      if (do_push)
      begin
         n.mem[s.wp] = wdata;
         n.wp        = s.wp + 1'b1;
      end
      if (do_pop)
         n.rp = s.rp + 1'b1;
      n.cnt = s.cnt + (A+1)'(do_push) - (A+1)'(do_pop);
      if (clr)
      begin
         n.rp  = '0;
         n.wp  = '0;
         n.cnt = '0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s <= '0;
      else
         s <= n;
   end

   property p_full_ignored;
      @(posedge hclk) disable iff (!hresetn) push && full && !pop && !clr |=> full && $stable(s.wp);
   endproperty
   a_full_ignored: assert property (p_full_ignored) else $error("write to full fifo taken");
endmodule : uef_fifo

// *** testbench/uef_peer.sv ***
`timescale 1ns/1ns
module uef_peer
(
   input  wire logic       hclk,     // clock
   input  wire logic       line,     // serial from block
   input  wire logic [1:0] fmt,      // expected format
   input  wire logic       two_stop, // two stop bits expected
   output logic            drive,    // serial to block
   output logic [8:0]      got,      // last word seen
   output logic            good,     // last frame well formed
   output int              frames    // frames seen
);
   // ----------------------------------------
   // receiver, samples mid-bit at 16 clocks per bit
   // ----------------------------------------
   initial
   begin
      logic [8:0] w;
      logic       ok;
      drive = 1'b1;
      frames = 0;
      forever
      begin
         @(negedge line);
         repeat (8) @(posedge hclk);
         ok = !line;
         w = '0;
         for (int i = 0; i < ((fmt == 2'h3) ? 9 : 8); i++)
         begin
            repeat (16) @(posedge hclk);
            w[i] = line;
         end
         if (fmt == 2'h1 || fmt == 2'h2)
         begin
            repeat (16) @(posedge hclk);
            ok &= (line == (^w[7:0] ^ (fmt == 2'h2)));
         end
         for (int s = 0; s <= int'(two_stop); s++)
         begin
            repeat (16) @(posedge hclk);
            ok &= line;
         end
         // results stand until the next frame ends
         got = w;
         good = ok;
         frames++;
      end
   end
   // one 8N1 frame, line left high after
   task send(input logic [7:0] b);
      drive <= 1'b0;
      repeat (16) @(posedge hclk);
      for (int i = 0; i < 8; i++)
      begin
         drive <= b[i];
         repeat (16) @(posedge hclk);
      end
      drive <= 1'b1;
      repeat (16) @(posedge hclk);
   endtask : send
endmodule : uef_peer

// *** testbench/tb_uart_enable_format_transmit.sv ***
`timescale 1ns/1ns
module tb_uart_enable_format_transmit
   import uef_pkg::*;
;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, two_stop = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0]  htrans = 0, fmt = 0, port_latch = 2'b10, port_direction = 2'b01;
   logic        hreadyout, hresp, tx_pin_o, tx_pin_oe, rx_pin_o, rx_pin_oe, tx_irq, rx_irq;
   logic        tx_line, rx_line, drive, good;
   logic [8:0]  got;
   int          frames, irqs = 0, rirqs = 0, failures = 0, total_checks = 0;
   assign tx_line = tx_pin_oe ? tx_pin_o : 1'b1;
   assign rx_line = rx_pin_oe ? rx_pin_o : drive;
   always #2 hclk = ~hclk;
   always @(posedge hclk) if (tx_irq === 1'b1) irqs <= irqs + 1;
   always @(posedge hclk) if (rx_irq === 1'b1) rirqs <= rirqs + 1;
   uef_uart DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
      .hreadyout, .hresp, .hrdata, .port_latch, .port_direction, .tx_pin_i(tx_line), .tx_pin_o, .tx_pin_oe,
      .rx_pin_i(rx_line), .rx_pin_o, .rx_pin_oe, .tx_irq, .rx_irq);
   uef_peer peer (.hclk, .line(tx_line), .fmt, .two_stop, .drive, .got, .good, .frames);
   task end_of_test;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_of_test
   task chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
      begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : xfer
   task wait_frames(input int n);
      for (int i = 0; i < 3000 && frames < n; i++) @(posedge hclk);
      chk(frames, n);
      repeat (24) @(posedge hclk);
   endtask : wait_frames
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_reset;
      xfer(0, A_MODE, 0);
      chk(rd, 32'h0);
      xfer(0, A_STATE, 0);
      chk(rd, 32'h0110);
      xfer(0, 8'h14, 0);
      chk(rd, 32'h0);
      chk({tx_pin_oe, rx_pin_oe, rx_pin_o, tx_pin_o}, 4'b0110);
      chk({hresp, hreadyout}, 2'b01);
   endtask : t_reset
   task t_enable;
      xfer(1, A_BAUD, 32'h0);
      xfer(1, A_MODE, 32'h8000);
      repeat (2) @(posedge hclk);
      chk({tx_pin_oe, rx_pin_oe, tx_line}, 3'b101);
   endtask : t_enable
   task t_format;
      logic [8:0] v;
      int n, i0;
      for (int k = 0; k < 8; k++)
      begin
         fmt <= 2'(k >> 1);
         two_stop <= k[0];
         xfer(1, A_MODE, 32'(k));
         xfer(1, A_MODE, 32'h8000 | 32'(k));
         xfer(1, A_STATE, 32'h0400);
         v = {k >= 6, 8'hb1 + 8'(k)};
         n = frames + 1;
         i0 = irqs;
         xfer(1, A_TXW, 32'(v));
         wait_frames(n);
         chk({good, got}, {1'b1, v});
         chk(irqs - i0, 1);
      end
   endtask : t_format
   task t_fill;
      int n, i0;
      fmt <= 2'h0;
      two_stop <= 1'b0;
      xfer(1, A_MODE, 32'h0);
      xfer(1, A_MODE, 32'h8000);
      xfer(1, A_STATE, 32'h8000);
      for (int k = 1; k <= 5; k++) xfer(1, A_TXW, 32'(k));
      xfer(0, A_STATE, 0);
      chk(rd[9], 1'b1);
      n = frames;
      i0 = irqs;
      xfer(1, A_STATE, 32'h8400);
      for (int i = 0; i < 6 && tx_line; i++) @(posedge hclk);
      chk(tx_line, 1'b0);
      for (int k = 1; k <= 4; k++)
      begin
         wait_frames(n + k);
         chk(got, 9'(k));
      end
      chk(irqs - i0, 1);
      repeat (300) @(posedge hclk);
      chk(frames, n + 4);
   endtask : t_fill
   task t_disable;
      int n;
      xfer(1, A_STATE, 32'h8460);
      xfer(1, A_TXW, 32'h33);
      xfer(1, A_TXW, 32'h44);
      repeat (40) @(posedge hclk);
      xfer(1, A_MODE, 32'h0001);
      xfer(0, A_STATE, 0);
      chk(rd, 32'h8170);
      xfer(0, A_MODE, 0);
      chk(rd, 32'h0001);
      chk(tx_pin_oe, 1'b0);
      repeat (300) @(posedge hclk);
      n = frames;
      two_stop <= 1'b1;
      xfer(1, A_MODE, 32'h8001);
      xfer(1, A_STATE, 32'h0400);
      repeat (400) @(posedge hclk);
      chk(frames, n);
      xfer(1, A_TXW, 32'h66);
      wait_frames(n + 1);
      chk({good, got}, {1'b1, 9'h066});
   endtask : t_disable
   task t_rx;
      int n, r0;
      r0 = rirqs;
      peer.send(8'hc3);
      repeat (20) @(posedge hclk);
      xfer(0, A_STATE, 0);
      chk(rd[0], 1'b1);
      xfer(0, A_RXR, 0);
      chk(rd, 32'h00c3);
      n = frames + 1;
      xfer(1, A_MODE, 32'h8041);
      xfer(1, A_TXW, 32'h5a);
      wait_frames(n);
      chk({good, got}, {1'b1, 9'h05a});
      xfer(0, A_RXR, 0);
      chk(rd, 32'h005a);
      chk(rirqs - r0, 2);
   endtask : t_rx
   initial
   begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_enable;
      t_format;
      t_fill;
      t_disable;
      t_rx;
      end_of_test;
   end
   initial
   begin
      repeat (30000) @(posedge hclk);
      failures++;
      end_of_test;
   end
endmodule : tb_uart_enable_format_transmit
